// [common/sfp_pkg.sv]
// Shared constants, types and the frame checksum for the serial frame port.
// Assumes a single system clock; all pin timing is recovered by sampling.
package sfp_pkg;
  // Frame lengths in falling serial clock edges
  localparam int SFP_LEN_PLAIN = 24;
  localparam int SFP_LEN_CRC = 32;
  localparam int SFP_CNT_W = 6;
  localparam logic [5:0] SFP_CNT_MAX = 6'h3f;
  localparam logic [5:0] SFP_MIN_PLAIN = 6'h18;
  localparam logic [5:0] SFP_MIN_CRC = 6'h20;
  // Checksum generator x^8+x^2+x+1, start value, no final inversion
  localparam logic [7:0] SFP_CRC_POLY = 8'h07;
  localparam logic [7:0] SFP_CRC_INIT = 8'h00;
  // Reset values
  localparam logic [31:0] SFP_RESP_RST = 32'h0000_0000;

  // Command word, packed exactly as frame bits 23:0
  typedef struct packed {
    logic rw;
    logic [2:0] rsv;
    logic [3:0] addr;
    logic [15:0] data;
  } sfp_cmd_t;

  typedef enum logic [1:0] {
    SFP_IDLE = 2'b00,
    SFP_SHIFT = 2'b01,
    SFP_EVAL = 2'b10,
    SFP_RESP = 2'b11
  } sfp_state_t;

  // Bitwise checksum, MSB first
  function automatic logic [7:0] sfp_crc8(input logic [23:0] d);
    logic [7:0] c;
    logic fb;
    c = SFP_CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? SFP_CRC_POLY : 8'h00);
    end
    return c;
  endfunction
endpackage

// [logic/sfp_port.sv]
// Serial frame port with optional checksum: shifts host frames, decodes
// write and read commands, returns answers and chains to a further device.
// Assumes register storage sits outside on clk_sys; pins arrive unsynchronised.
//
// Contract
// - Accept free or gated serial clock; sample input on falling edges.
// - Frames shorter than the minimum are discarded entirely.
// - Longer frames use only the last 24 or 32 shifted bits.
// - Chip select high: ignore clock and input, output in high impedance.
// - Plain frame: flag bit 23, zeros 22:20, address 19:16, data 15:0.
// - Write stores the data field; read ignores it.
// - Read answer echoes flag, zeros and address, then register contents.
// - Output bits launch on rising or falling edge per edge select.
// - Beyond 24 pulses, bits leaving the shifter appear on the output.
// - Chip select rising moves the frame inward and stops shifting.
// - A configuration bit enables checking; frames become 32 bits.
// - The checksum is the 8-bit CRC x^8+x^2+x+1.
// - At chip select rising check the 32-bit frame; accept on zero remainder.
// - A write failing the check changes no register.
// - With checking on every output frame ends in an 8-bit CRC.
// - After a checked write echo flag, address, data, error bit 30, CRC.
// - Alarm enabled with source zero turns the output pin into CRC alarm.
`timescale 1ns/100ps
module sfp_port
  import sfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic serial_out_alarm_pin,
  output logic serial_out_alarm_pin_oe,
  input wire logic crc_enable,
  input wire logic sdo_edge_select,
  input wire logic alarm_pin_enable,
  input wire logic alarm_source_select,
  output logic wr_valid,
  output sfp_cmd_t wr_cmd,
  output logic [3:0] rd_addr,
  input wire logic [15:0] rd_data,
  output logic crc_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds only stage two
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic cs_prev;
  logic sclk_prev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      cs_prev <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      sync1 <= {cs_n, sclk, sdi};
      sync2 <= sync1;
      cs_prev <= sync2[2];
      sclk_prev <= sync2[1];
    end
  end

  logic cs_s;
  logic sdi_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;

  // Edges found by the system clock; serial clock may run or stop freely
  assign cs_s = sync2[2];
  assign sdi_s = sync2[0];
  assign cs_fall = cs_prev & ~cs_s;
  assign cs_rise = ~cs_prev & cs_s;
  assign sclk_fall = sclk_prev & ~sync2[1];
  assign sclk_rise = ~sclk_prev & sync2[1];

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine state
  sfp_state_t state, next_state;
  logic [31:0] shreg, next_shreg;
  logic [SFP_CNT_W-1:0] cnt, next_cnt;
  logic [31:0] resp, next_resp;
  sfp_cmd_t cmd, next_cmd;
  logic sdo_q, next_sdo_q;
  logic crc_err, next_crc_err;
  logic next_wr_valid;
  sfp_cmd_t next_wr_cmd;
  logic [3:0] next_rd_addr;

  logic [5:0] min_len;
  logic top_bit;
  logic next_top;
  sfp_cmd_t cmd_in;
  logic crc_ok;
  logic [15:0] ans_data;
  logic [23:0] ans_head;
  logic [31:0] ans;

  // Length and field selection follow the checking mode
  assign min_len = crc_enable ? SFP_MIN_CRC : SFP_MIN_PLAIN;
  assign top_bit = crc_enable ? shreg[31] : shreg[23];
  assign next_top = crc_enable ? shreg[30] : shreg[22];
  assign cmd_in = crc_enable ? shreg[31:8] : shreg[23:0];
  assign crc_ok = !crc_enable || (sfp_crc8(shreg[31:8]) == shreg[7:0]);

  // Answer word built from the latched command
  assign ans_data = cmd.rw ? rd_data : cmd.data;
  assign ans_head = {cmd.rw, 3'h0, cmd.addr, ans_data};
  assign ans = crc_enable
    ? {cmd.rw, crc_err, 2'h0, cmd.addr, ans_data,
       sfp_crc8({cmd.rw, crc_err, 2'h0, cmd.addr, ans_data})}
    : {8'h00, ans_head};

  // Next-value logic of the frame engine
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = cnt;
    next_resp = resp;
    next_cmd = cmd;
    next_sdo_q = sdo_q;
    next_crc_err = crc_err;
    next_wr_valid = 1'b0;
    next_wr_cmd = wr_cmd;
    next_rd_addr = rd_addr;
    case (state)
      SFP_IDLE: begin
        // Answer preloads the shifter so it leaves ahead of chained data
        if (cs_fall) begin
          next_state = SFP_SHIFT;
          next_shreg = resp;
          next_cnt = '0;
          next_sdo_q = crc_enable ? resp[31] : resp[23];
        end
      end
      SFP_SHIFT: begin
        if (cs_rise) begin
          next_state = SFP_EVAL;
        end else if (sclk_fall) begin
          next_shreg = {shreg[30:0], sdi_s};
          if (cnt != SFP_CNT_MAX) begin
            next_cnt = cnt + 6'h01;
          end
          if (sdo_edge_select) begin
            next_sdo_q = next_top;
          end
        end else if (sclk_rise && !sdo_edge_select) begin
          next_sdo_q = top_bit;
        end
      end
      SFP_EVAL: begin
        if (cnt < min_len) begin
          next_state = SFP_IDLE;
        end else begin
          next_state = SFP_RESP;
          next_cmd = cmd_in;
          next_rd_addr = cmd_in.addr;
          if (crc_enable) begin
            next_crc_err = !crc_ok;
          end
          // Failed check blocks the store
          if (!cmd_in.rw && crc_ok) begin
            next_wr_valid = 1'b1;
            next_wr_cmd = cmd_in;
          end
        end
      end
      SFP_RESP: begin
        // Read data sampled one cycle after the address went out
        next_resp = ans;
        next_state = SFP_IDLE;
        if (cs_fall) begin
          next_state = SFP_SHIFT;
          next_shreg = ans;
          next_cnt = '0;
          next_sdo_q = crc_enable ? ans[31] : ans[23];
        end
      end
      default: begin
        next_state = SFP_IDLE;
      end
    endcase
  end

  // Frame engine registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= SFP_IDLE;
      shreg <= SFP_RESP_RST;
      cnt <= '0;
      resp <= SFP_RESP_RST;
      cmd <= '0;
      sdo_q <= 1'b0;
      crc_err <= 1'b0;
      wr_valid <= 1'b0;
      wr_cmd <= '0;
      rd_addr <= 4'h0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      cnt <= next_cnt;
      resp <= next_resp;
      cmd <= next_cmd;
      sdo_q <= next_sdo_q;
      crc_err <= next_crc_err;
      wr_valid <= next_wr_valid;
      wr_cmd <= next_wr_cmd;
      rd_addr <= next_rd_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared output pin; alarm mode overrides data and keeps driving
  logic alarm_mode;

  assign alarm_mode = alarm_pin_enable && !alarm_source_select;
  assign serial_out_alarm_pin = alarm_mode ? crc_err : sdo_q;
  assign serial_out_alarm_pin_oe = alarm_mode | ~cs_s;
  assign crc_error = crc_err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence sq_end;
    (state == SFP_SHIFT && cs_rise) ##1 (state == SFP_EVAL);
  endsequence

  sequence sq_good_write;
    state == SFP_EVAL && cnt >= min_len && crc_ok && !cmd_in.rw;
  endsequence

  AST_DISCARD: assert property (
    state == SFP_EVAL && cnt < min_len |=> state == SFP_IDLE && !wr_valid)
    else $error("short frame not discarded");

  AST_BAD_CRC_NO_WRITE: assert property (
    state == SFP_EVAL && crc_enable && !crc_ok |=> !wr_valid ##1 !wr_valid)
    else $error("write despite checksum failure");

  AST_HIZ: assert property (
    cs_s && !alarm_mode |-> !serial_out_alarm_pin_oe)
    else $error("output driven with chip select high");

  AST_SAMPLE_FALL: assert property (
    state == SFP_SHIFT && sclk_fall && !cs_rise |=> shreg[0] == $past(sdi_s)
      && shreg[31:1] == $past(shreg[30:0]))
    else $error("input not shifted on falling edge");

  AST_WRITE: assert property (
    sq_good_write |=> wr_valid && wr_cmd == $past(cmd_in))
    else $error("good write not stored");

  AST_RESP_CRC: assert property (
    state == SFP_RESP && crc_enable |=> resp[7:0] == sfp_crc8(resp[31:8]))
    else $error("answer checksum wrong");

  AST_READ_ECHO: assert property (
    state == SFP_RESP && cmd.rw && !crc_enable
      |=> resp[23:0] == {1'b1, 3'h0, $past(cmd.addr), $past(rd_data)})
    else $error("read answer mismatch");

  AST_ALARM: assert property (
    alarm_mode |-> serial_out_alarm_pin_oe && serial_out_alarm_pin == crc_err)
    else $error("alarm pin not showing checksum error");

  AST_FRAME_END: assert property (
    sq_end |-> $stable(shreg) && $stable(cnt))
    else $error("shifting continued after chip select rose");

  AST_RISE_LAUNCH: assert property (
    state == SFP_SHIFT && sclk_rise && !sdo_edge_select && !cs_rise
      |=> sdo_q == $past(top_bit))
    else $error("output not launched on rising edge");

  // Chain output: after a fall the pin bit is the one now leaving the shifter
  AST_CHAIN_OUT: assert property (
    state == SFP_SHIFT && sclk_fall && sdo_edge_select && !cs_rise
      |=> sdo_q == top_bit)
    else $error("chained bit not on output after falling edge");

  // Idle ignores link clock and data, so nothing leaks into the next frame
  AST_IDLE_HOLD: assert property (
    state == SFP_IDLE && !cs_fall |=> $stable(shreg) && $stable(cnt))
    else $error("shifter moved with chip select high");

  // A short frame must not disturb the answer or the error flag either
  AST_SHORT_KEEP: assert property (
    state == SFP_EVAL && cnt < min_len |=> $stable(resp) && $stable(crc_err))
    else $error("short frame changed answer or error flag");

  // Error flag follows the check of every full checked frame
  AST_CRC_FLAG: assert property (
    state == SFP_EVAL && cnt >= min_len && crc_enable |=> crc_err == !$past(crc_ok))
    else $error("checksum error flag wrong");

endmodule

// [test/sfp_host.sv]
// Host controller model: drives chip select, serial clock and data in.
// Assumes the bench resolves the output pin and feeds the wire level back.
`timescale 1ns/100ps
module sfp_host (
  input wire logic clk_sys,
  input wire logic sdo_wire,
  input wire logic sdo_edge_select,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  ////////////////////
  // Idle: clock stands still low, chip select high
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One access, MSB first; sel=0 toggles the pins with chip select high
  task automatic xfer(input logic [63:0] tx, input int n, input logic sel, output logic [63:0] rx);
    rx = '0;
    @(posedge clk_sys);
    #1 cs_n = !sel;
    #64;
    for (int i = n - 1; i >= 0; i--) begin
      #32;
      if (sdo_edge_select) rx[i] = sdo_wire;
      sclk = 1'b1;
      // Data moves on the rising edge so it holds well past the sampling fall
      sdi = tx[i];
      #32;
      if (!sdo_edge_select) rx[i] = sdo_wire;
      sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    sdi = ~sdi; // Released line never keeps a stale level
    #64;
  endtask
endmodule

// [test/tb_top.sv]
// Bench for the serial frame port: host model on the pins, register file behind.
// Assumes a 125 MHz system clock and a 64 ns host serial clock.
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
  import sfp_pkg::*;
  logic clk_sys, rst_n, cs_n, sclk, sdi, serial_out_alarm_pin, serial_out_alarm_pin_oe, sdo_wire;
  logic crc_enable, sdo_edge_select, alarm_pin_enable, alarm_source_select, wr_valid, crc_error;
  sfp_cmd_t wr_cmd;
  logic [3:0] rd_addr;
  logic [15:0] rd_data, d;
  logic [15:0] regs [16];
  logic [63:0] rx;
  int error_cnt, cmp_count, wr_cnt;

  sfp_port uut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .serial_out_alarm_pin(serial_out_alarm_pin),
    .serial_out_alarm_pin_oe(serial_out_alarm_pin_oe),
    .crc_enable(crc_enable),
    .sdo_edge_select(sdo_edge_select),
    .alarm_pin_enable(alarm_pin_enable),
    .alarm_source_select(alarm_source_select),
    .wr_valid(wr_valid),
    .wr_cmd(wr_cmd),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .crc_error(crc_error)
  );
  sfp_host host (
    .clk_sys(clk_sys),
    .sdo_wire(sdo_wire),
    .sdo_edge_select(sdo_edge_select),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi)
  );

  ////////////////////
  // Pin wire has no pull, so an undriven pin reads as z
  assign sdo_wire = serial_out_alarm_pin_oe ? serial_out_alarm_pin : 1'bz;
  assign rd_data = regs[rd_addr];
  always #4 clk_sys = ~clk_sys;

  // Register file written on each store pulse
  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1) begin
      regs[wr_cmd.addr] <= wr_cmd.data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  function automatic logic [7:0] crc_of(input logic [23:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  // Whole frame; flip corrupts the checksum; waits out the evaluation
  task automatic frame(input logic [23:0] w, input logic [7:0] flip);
    if (crc_enable) host.xfer({32'h0, w, crc_of(w) ^ flip}, 32, 1'b1, rx);
    else host.xfer({40'h0, w}, 24, 1'b1, rx);
    repeat (4) step();
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////
  // Watchdog sized well above the roughly 26 us of traffic
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {crc_enable, sdo_edge_select, alarm_pin_enable, alarm_source_select} = 4'h0;
    foreach (regs[i]) regs[i] = 16'h5a5a;
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    `CHK(serial_out_alarm_pin_oe, 1'b0)
    // Write, read, fetch in both output edge modes
    for (int e = 0; e < 2; e++) begin
      sdo_edge_select = e[0];
      d = e[0] ? 16'h3c5a : 16'ha5c3;
      frame({8'h03, d}, 8'h00);
      `CHK(regs[3], d)
      frame(24'h83ffff, 8'h00);
      `CHK(rx[23:0], {8'h03, d})
      `CHK(regs[3], d)
      frame(24'h800000, 8'h00);
      `CHK(rx[23:0], {8'h83, d})
      $display("test edge %0d done", e);
    end
    // Short frame dropped, long frame keeps last bits and chains out
    host.xfer({40'h0, 24'h051234}, 23, 1'b1, rx);
    repeat (4) step();
    `CHK(regs[5], 16'h5a5a)
    host.xfer({16'h0, 24'h8c1357, 24'h061234}, 48, 1'b1, rx);
    repeat (4) step();
    `CHK(regs[6], 16'h1234)
    `CHK(rx[47:0], {24'h805a5a, 24'h8c1357})
    host.xfer({40'h0, 24'h07beef}, 24, 1'b0, rx);
    `CHK(rx[23:0], {24{1'bz}})
    `CHK(regs[7], 16'h5a5a)
    `CHK(wr_cnt, 3)
    $display("test chain done");
    // Checked frames, bad checksum and alarm pin
    crc_enable = 1'b1;
    sdo_edge_select = 1'b0;
    frame(24'h02beef, 8'h00);
    `CHK(regs[2], 16'hbeef)
    `CHK(crc_error, 1'b0)
    frame(24'h020000, 8'h01);
    `CHK(regs[2], 16'hbeef)
    `CHK(crc_error, 1'b1)
    alarm_pin_enable = 1'b1;
    step();
    `CHK({serial_out_alarm_pin_oe, serial_out_alarm_pin}, 2'b11)
    alarm_source_select = 1'b1;
    step();
    `CHK(serial_out_alarm_pin_oe, 1'b0)
    {alarm_pin_enable, alarm_source_select} = 2'b00;
    frame(24'h820000, 8'h00);
    `CHK(rx[31:0], {24'h420000, crc_of(24'h420000)})
    frame(24'h800000, 8'h00);
    `CHK(rx[31:0], {24'h82beef, crc_of(24'h82beef)})
    `CHK(crc_error, 1'b0)
    $display("test crc done");
    test_done();
  end
endmodule
